// ===== core/pin_route_pkg.sv
// Constants for the pin function routing block
package pin_route_pkg;
    // ==============================================
    // Package variants and pin identifiers
    localparam logic [1:0] VAR_SMALL = 2'h0;
    localparam logic [1:0] VAR_MID   = 2'h1;
    localparam logic [1:0] VAR_LARGE = 2'h2;
    localparam int PIN_W  = 5;
    localparam int N_PINS = 24;
    localparam logic [4:0] PA0 = 5'h00, PA1 = 5'h01, PA2 = 5'h02;
    localparam logic [4:0] PA3 = 5'h03, PA4 = 5'h04, PA5 = 5'h05;
    localparam logic [4:0] PA6 = 5'h06, PA7 = 5'h07, PB0 = 5'h08;
    localparam logic [4:0] PB1 = 5'h09, PB2 = 5'h0a, PB3 = 5'h0b;
    localparam logic [4:0] PB4 = 5'h0c, PB5 = 5'h0d, PB6 = 5'h0e;
    localparam logic [4:0] PB7 = 5'h0f, PC0 = 5'h10, PC1 = 5'h11;
    localparam logic [4:0] PC2 = 5'h12, PC3 = 5'h13, PC4 = 5'h14;
    localparam logic [4:0] PC6 = 5'h16, PC7 = 5'h17;
    // ==============================================
    // Function slots, highest first: int t0 t1 pfd pulse_width_out_0 pulse_width_out_1
    localparam int F_INT = 5, F_T0 = 4, F_T1 = 3;
    localparam int F_PFD = 2, F_PULSE_WIDTH_OUT_0 = 1, F_PULSE_WIDTH_OUT_1 = 0;
    localparam int N_FN = 6;
    localparam int N_AN = 5;
    localparam logic [5:0] FN_IS_OUT   = 6'h07;
    localparam logic [5:0] FN_OK_SMALL = 6'h36;
    localparam logic [5:0] FN_OK_MID   = 6'h3e;
    localparam logic [5:0] FN_OK_ALL   = 6'h3f;
    localparam logic [4:0] AN_OK_SMALL = 5'h01;
    localparam logic [4:0] AN_OK_ALL   = 5'h1f;
    localparam logic [1:0] SEL_0 = 2'h0, SEL_1 = 2'h1;
    localparam logic [1:0] SEL_2 = 2'h2, SEL_3 = 2'h3;
    localparam logic [19:0] LCD_MAP = {PC7, PC6, PB7, PB6};
    // ==============================================
    // Register map and fields
    localparam logic [7:0] OFS_ROUTE  = 8'h00;
    localparam logic [7:0] OFS_WAKE   = 8'h04;
    localparam logic [7:0] OFS_PULL_A = 8'h08;
    localparam logic [7:0] OFS_PULL_B = 8'h0c;
    localparam logic [7:0] OFS_PULL_C = 8'h10;
    localparam logic [7:0] OFS_PULL_D = 8'h14;
    localparam logic [7:0] OFS_LCD    = 8'h18;
    localparam logic [7:0] OFS_OSC    = 8'h1c;
    localparam logic [7:0] ROUTE_MASK_SMALL = 8'h0d;
    localparam logic [7:0] ROUTE_MASK_MID   = 8'h0c;
    localparam logic [7:0] ROUTE_MASK_LARGE = 8'h0f;
    localparam logic [7:0] LCD_MASK = 8'h3f;
    localparam logic [7:0] OSC_MASK = 8'h37;
    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic [7:0] OSC_RST  = 8'h02;
    localparam int SEL_LO = 2, AN_LO = 0, LCD_BIAS_LO = 4, RC_LO = 4;
    // ==============================================
    // Oscillator sources and fast RC frequencies
    localparam logic [2:0] OSC_FAST_XTAL = 3'h0;
    localparam logic [2:0] OSC_EXT_RC    = 3'h1;
    localparam logic [2:0] OSC_FAST_RC   = 3'h2;
    localparam logic [2:0] OSC_SLOW_XTAL = 3'h3;
    localparam logic [2:0] OSC_SLOW_RC   = 3'h4;
    localparam logic [1:0] RC_4MHZ = 2'h0, RC_8MHZ = 2'h1, RC_12MHZ = 2'h2;
    localparam logic [1:0] OSC_USE_BOTH  = 2'h3;
    localparam logic [1:0] OSC_USE_FIRST = 2'h2;
    localparam logic [1:0] OSC_USE_NONE  = 2'h0;
endpackage

// ===== core/pin_function_route.sv
// Pin function routing, pull-high, wake, LCD common and clock select
// What this block does
// - Route register resets to zero; upper and unimplemented bits read zero.
// - Small part, select 00/01 places int, t0, pfd, pulse_width_out_0 on port A.
// - Small part, select 10 places them on PB1, PB2, PB0, PA7.
// - Small part, bit 0 moves analog 3 from PA5 to PA3.
// - Middle part, select 00 routes five functions to port A; 01, 10 unused.
// - Middle part, select 11 routes them to PC3, PC4, PA6, PC2, PA7.
// - Large part, select 00 routes six functions to PA0/2/6/1/7, PC1.
// - Large part, select 01 routes them to PA3/2/4/1/7, PB4.
// - Large part, select 10 routes them to PA0/2/4/1/7, PB4.
// - Large part, select 11 routes them to PC3/4, PA6, PC2, PA7, PC1.
// - Large part, analog 00 puts channels 7..3 on PB1/0/3/2/5.
// - Large part, analog 01 puts channels 7..3 on PC0, PA6/5/4/3.
// - Large part, analog 10 puts channels 7..3 on PC0, PA6, PA5, PB2, PA5.
// - Large part, analog 11 puts channels 7..3 on PB1/0/3/2, PA3.
// - In sleep, a falling edge on an enabled port A pin wakes.
// - Pull-high only on input pins whose select bit is set.
// - PB6, PB7, PC6, PC7 can be LCD common lines with set bias.
// - Five oscillator sources, three fast and two slow.
// - Fast internal RC runs at 4, 8 or 12 MHz.
// - External RC takes only the first oscillator pin; PA5 stays I/O.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pin_function_route
    import pin_route_pkg::*;
#(
    parameter logic [1:0] VARIANT = VAR_LARGE
)
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata_ff,
    output logic             pready_ff,
    output logic             pslverr_ff,
    // Pads of ports A, B, C (index port*8+bit) and port D
    input  wire logic [23:0] pin_in,
    input  wire logic [23:0] gpio_out,
    input  wire logic [23:0] gpio_is_input,
    input  wire logic [7:0]  gpio_d_is_input,
    output logic      [23:0] pad_out_ff,
    output logic      [23:0] pad_oe_ff,
    output logic      [23:0] pad_pull_ff,
    output logic      [23:0] pad_analog_ff,
    output logic      [7:0]  pad_d_pull_ff,
    // Peripheral functions
    input  wire logic        freq_div_in,
    input  wire logic        pulse_width_out_0_in,
    input  wire logic        pulse_width_out_1_in,
    output logic             ext_interrupt_ff,
    output logic             timer0_clock_input_ff,
    output logic             timer1_clock_input_ff,
    // Sleep and wake
    input  wire logic        sleep_mode,
    output logic             wake_req_ff,
    // LCD common lines and oscillator
    output logic      [3:0]  lcd_common_line_ff,
    output logic      [1:0]  lcd_bias_level_ff,
    output logic      [2:0]  osc_source_ff,
    output logic      [1:0]  fast_rc_freq_ff,
    output logic      [1:0]  osc_pin_used_ff
);
    // ==============================================
    // Register file
    logic [7:0]  route_ff, wake_ff, pull_a_ff, pull_b_ff;
    logic [7:0]  pull_c_ff, pull_d_ff, lcd_ff, osc_ff;
    logic [7:0]  nxt_route, nxt_wake, nxt_pull_a, nxt_pull_b;
    logic [7:0]  nxt_pull_c, nxt_pull_d, nxt_lcd, nxt_osc;
    logic [31:0] nxt_prdata;
    logic        nxt_pready, nxt_pslverr;
    logic [7:0]  route_mask, rd;
    logic        miss, wr;

    always_comb
    begin
        case (VARIANT)
        VAR_SMALL: route_mask = ROUTE_MASK_SMALL;
        VAR_MID:   route_mask = ROUTE_MASK_MID;
        default:   route_mask = ROUTE_MASK_LARGE;
        endcase
        miss = 1'b0;
        case (paddr)
        OFS_ROUTE:  rd = route_ff;
        OFS_WAKE:   rd = wake_ff;
        OFS_PULL_A: rd = pull_a_ff;
        OFS_PULL_B: rd = pull_b_ff;
        OFS_PULL_C: rd = pull_c_ff;
        OFS_PULL_D: rd = pull_d_ff;
        OFS_LCD:    rd = lcd_ff;
        OFS_OSC:    rd = osc_ff;
        default:
        begin
            rd = REG_RST;
            miss = 1'b1;
        end
        endcase
        // Zero-wait: ready is raised for the access phase only
        nxt_pready = psel & ~penable;
        nxt_pslverr = psel & ~penable & miss;
        nxt_prdata = prdata_ff;
        if (psel && !penable)
            nxt_prdata = {24'h000000, rd};
        wr = psel & penable & pready_ff & pwrite;
        {nxt_route, nxt_wake, nxt_pull_a, nxt_pull_b} =
            {route_ff, wake_ff, pull_a_ff, pull_b_ff};
        {nxt_pull_c, nxt_pull_d, nxt_lcd, nxt_osc} =
            {pull_c_ff, pull_d_ff, lcd_ff, osc_ff};
        if (wr)
        begin
            case (paddr)
            OFS_ROUTE:  nxt_route = pwdata[7:0] & route_mask;
            OFS_WAKE:   nxt_wake = pwdata[7:0];
            OFS_PULL_A: nxt_pull_a = pwdata[7:0];
            OFS_PULL_B: nxt_pull_b = pwdata[7:0];
            OFS_PULL_C: nxt_pull_c = pwdata[7:0];
            OFS_PULL_D: nxt_pull_d = pwdata[7:0];
            OFS_LCD:    nxt_lcd = pwdata[7:0] & LCD_MASK;
            OFS_OSC:    nxt_osc = pwdata[7:0] & OSC_MASK;
            default:    nxt_osc = osc_ff;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            {route_ff, wake_ff, pull_a_ff, pull_b_ff} <= {4{REG_RST}};
            {pull_c_ff, pull_d_ff, lcd_ff} <= {3{REG_RST}};
            osc_ff <= OSC_RST;
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            {route_ff, wake_ff, pull_a_ff, pull_b_ff} <=
                {nxt_route, nxt_wake, nxt_pull_a, nxt_pull_b};
            {pull_c_ff, pull_d_ff, lcd_ff, osc_ff} <=
                {nxt_pull_c, nxt_pull_d, nxt_lcd, nxt_osc};
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // LCD lines and clock source straight from their registers
    assign lcd_common_line_ff = lcd_ff[3:0];
    assign lcd_bias_level_ff = lcd_ff[LCD_BIAS_LO +: 2];
    assign osc_source_ff = osc_ff[2:0];
    assign fast_rc_freq_ff = osc_ff[RC_LO +: 2];

    // ==============================================
    // Route decode
    logic [29:0] fn_map;
    logic [5:0]  fn_ok;
    logic [24:0] an_map;
    logic [4:0]  an_ok;
    logic [1:0]  sel, asel, osc_use;

    assign sel = route_ff[SEL_LO +: 2];
    assign asel = route_ff[AN_LO +: 2];

    always_comb
    begin
        {fn_map, fn_ok, an_map, an_ok} = '0;
        case (VARIANT)
        VAR_SMALL:
        begin
            fn_ok = FN_OK_SMALL;
            case (sel)
            SEL_0:   fn_map = {PA0, PA2, PA0, PA1, PA7, PA0};
            SEL_1:   fn_map = {PA3, PA2, PA0, PA1, PA4, PA0};
            SEL_2:   fn_map = {PB1, PB2, PA0, PB0, PA7, PA0};
            default: fn_ok = '0;
            endcase
            an_ok = AN_OK_SMALL;
            an_map = {{4{PA0}}, route_ff[AN_LO] ? PA3 : PA5};
        end
        VAR_MID:
        begin
            fn_ok = FN_OK_MID;
            case (sel)
            SEL_0:   fn_map = {PA0, PA2, PA6, PA1, PA7, PA0};
            SEL_3:   fn_map = {PC3, PC4, PA6, PC2, PA7, PA0};
            default: fn_ok = '0;
            endcase
        end
        default:
        begin
            fn_ok = FN_OK_ALL;
            an_ok = AN_OK_ALL;
            case (sel)
            SEL_0:   fn_map = {PA0, PA2, PA6, PA1, PA7, PC1};
            SEL_1:   fn_map = {PA3, PA2, PA4, PA1, PA7, PB4};
            SEL_2:   fn_map = {PA0, PA2, PA4, PA1, PA7, PB4};
            default: fn_map = {PC3, PC4, PA6, PC2, PA7, PC1};
            endcase
            // Select 10 doubles PA5 and leaves PA4 free, kept as given
            case (asel)
            SEL_0:   an_map = {PB1, PB0, PB3, PB2, PB5};
            SEL_1:   an_map = {PC0, PA6, PA5, PA4, PA3};
            SEL_2:   an_map = {PC0, PA6, PA5, PB2, PA5};
            default: an_map = {PB1, PB0, PB3, PB2, PA3};
            endcase
        end
        endcase
        // Crystals need both oscillator pins, external RC only the first
        case (osc_ff[2:0])
        OSC_FAST_XTAL: osc_use = OSC_USE_BOTH;
        OSC_SLOW_XTAL: osc_use = OSC_USE_BOTH;
        OSC_EXT_RC:    osc_use = OSC_USE_FIRST;
        default:       osc_use = OSC_USE_NONE;
        endcase
    end

    // ==============================================
    // Pin input synchronisers and function inputs
    logic [23:0] sync1_ff, sync2_ff, sync3_ff, filt_ff, nxt_filt, agree;
    logic [23:0] nxt_out, nxt_oe, nxt_pull, nxt_analog, pull_sel;
    logic [5:0]  fn_val;
    logic        nxt_int, nxt_t0, nxt_t1, nxt_wake_req;

    always_comb
    begin
        agree = sync2_ff ~^ sync3_ff;
        nxt_filt = (sync3_ff & agree) | (filt_ff & ~agree);
        nxt_int = fn_ok[F_INT] & filt_ff[fn_map[F_INT*PIN_W +: PIN_W]];
        nxt_t0 = fn_ok[F_T0] & filt_ff[fn_map[F_T0*PIN_W +: PIN_W]];
        nxt_t1 = fn_ok[F_T1] & filt_ff[fn_map[F_T1*PIN_W +: PIN_W]];
        // Falling edge seen on the filtered level, so glitches cannot wake
        nxt_wake_req = sleep_mode & |(filt_ff[7:0] & ~nxt_filt[7:0]
                       & wake_ff);
    end

    // ==============================================
    // Pad muxing: oscillator, LCD, analog, then digital functions
    always_comb
    begin
        pull_sel = {pull_c_ff, pull_b_ff, pull_a_ff};
        fn_val = {3'h0, freq_div_in, pulse_width_out_0_in, pulse_width_out_1_in};
        for (int p = 0; p < N_PINS; p++)
        begin
            nxt_out[p] = gpio_out[p];
            nxt_oe[p] = ~gpio_is_input[p];
            nxt_analog[p] = 1'b0;
            nxt_pull[p] = gpio_is_input[p] & pull_sel[p];
            for (int f = 0; f < N_FN; f++)
            begin
                if (fn_ok[f] && fn_map[f*PIN_W +: PIN_W] == 5'(p))
                begin
                    nxt_out[p] = fn_val[f];
                    nxt_oe[p] = FN_IS_OUT[f];
                    nxt_pull[p] = nxt_pull[p] & ~FN_IS_OUT[f];
                end
            end
            for (int a = 0; a < N_AN; a++)
            begin
                if (an_ok[a] && an_map[a*PIN_W +: PIN_W] == 5'(p))
                begin
                    nxt_analog[p] = 1'b1;
                    nxt_oe[p] = 1'b0;
                    nxt_pull[p] = 1'b0;
                end
            end
            for (int l = 0; l < 4; l++)
            begin
                if (lcd_ff[l] && LCD_MAP[l*PIN_W +: PIN_W] == 5'(p))
                begin
                    nxt_oe[p] = 1'b0;
                    nxt_pull[p] = 1'b0;
                    nxt_analog[p] = 1'b0;
                end
            end
            if ((osc_use[1] && 5'(p) == PA6) ||
                (osc_use[0] && 5'(p) == PA5))
            begin
                nxt_oe[p] = 1'b0;
                nxt_pull[p] = 1'b0;
                nxt_analog[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            {sync1_ff, sync2_ff, sync3_ff, filt_ff} <= '0;
            {pad_out_ff, pad_oe_ff, pad_pull_ff, pad_analog_ff} <= '0;
            pad_d_pull_ff <= '0;
            ext_interrupt_ff <= 1'b0;
            timer0_clock_input_ff <= 1'b0;
            timer1_clock_input_ff <= 1'b0;
            wake_req_ff <= 1'b0;
            osc_pin_used_ff <= OSC_USE_NONE;
        end
        else
        begin
            {sync3_ff, sync2_ff, sync1_ff} <= {sync2_ff, sync1_ff, pin_in};
            filt_ff <= nxt_filt;
            {pad_out_ff, pad_oe_ff, pad_pull_ff, pad_analog_ff} <=
                {nxt_out, nxt_oe, nxt_pull, nxt_analog};
            pad_d_pull_ff <= gpio_d_is_input & pull_d_ff;
            ext_interrupt_ff <= nxt_int;
            timer0_clock_input_ff <= nxt_t0;
            timer1_clock_input_ff <= nxt_t1;
            wake_req_ff <= nxt_wake_req;
            osc_pin_used_ff <= osc_use;
        end
    end

    // ==============================================
    // Assertions
    a_route_zero_bits: assert property (@(posedge clock)
        disable iff (rst) (route_ff & ~route_mask) == REG_RST)
        else $error("route register holds unimplemented bits");
    a_small_sel0_pwm: assert property (@(posedge clock)
        disable iff (rst) (VARIANT == VAR_SMALL && sel == SEL_0)
        |=> pad_oe_ff[PA7] && pad_out_ff[PA7] == $past(pulse_width_out_0_in))
        else $error("pulse_width_out_0 not on PA7 for select 00");
    a_small_sel2_pfd: assert property (@(posedge clock)
        disable iff (rst) (VARIANT == VAR_SMALL && sel == SEL_2)
        |=> pad_oe_ff[PB0] && pad_out_ff[PB0] == $past(freq_div_in))
        else $error("frequency output not on PB0 for select 10");
    a_small_an3_move: assert property (@(posedge clock)
        disable iff (rst) (VARIANT == VAR_SMALL && route_ff[AN_LO])
        |=> pad_analog_ff[PA3] && !pad_analog_ff[PA5])
        else $error("analog 3 not moved to PA3");
    a_large_pulse_width_out_1_pc1: assert property (@(posedge clock)
        disable iff (rst) (VARIANT == VAR_LARGE && sel == SEL_3)
        |=> pad_oe_ff[PC1] && pad_out_ff[PC1] == $past(pulse_width_out_1_in))
        else $error("pulse_width_out_1 not on PC1 for select 11");
    a_large_an7_pc0: assert property (@(posedge clock)
        disable iff (rst) (VARIANT == VAR_LARGE && asel == SEL_1)
        |=> pad_analog_ff[PC0] && pad_analog_ff[PA4])
        else $error("analog 01 placement wrong");
    a_wake_on_fall: assert property (@(posedge clock)
        disable iff (rst) (sleep_mode
        && |(filt_ff[7:0] & ~nxt_filt[7:0] & wake_ff)) |=> wake_req_ff)
        else $error("missed wake on falling edge");
    a_pull_input_only: assert property (@(posedge clock)
        disable iff (rst) ##1 (pad_pull_ff
        & ~$past(gpio_is_input & pull_sel)) == '0)
        else $error("pull-high on a pin that is not a selected input");
    a_ext_rc_pins: assert property (@(posedge clock)
        disable iff (rst) osc_ff[2:0] == OSC_EXT_RC
        |=> osc_pin_used_ff == OSC_USE_FIRST && (pad_analog_ff[PA5]
        || pad_oe_ff[PA5] != $past(gpio_is_input[PA5])))
        else $error("external RC claims the second oscillator pin");
    a_apb_ready: assert property (@(posedge clock)
        disable iff (rst) (psel && !penable) |=> pready_ff ##1 !pready_ff)
        else $error("APB ready not a single access-phase pulse");
endmodule // pin_function_route
`default_nettype wire

// ===== verif/test_pin_function_route.sv
// Self-checking testbench for the pin function routing block
`timescale 1ns/10ps
`default_nettype none
module test_pin_function_route;
    import pin_route_pkg::*;
    // ==========================================
    // Signals
    logic        clock, rst, psel, penable, pwrite;
    logic [7:0]  paddr, gpio_d_is_input, pad_d_pull_ff;
    logic [31:0] pwdata, prdata_ff, rd;
    logic        pready_ff, pslverr_ff, err;
    logic [23:0] pin_in, gpio_out, gpio_is_input;
    logic [23:0] pad_out_ff, pad_oe_ff, pad_pull_ff, pad_analog_ff;
    logic        freq_div_in, pulse_width_out_0_in, pulse_width_out_1_in, sleep_mode, wake_req_ff;
    logic        ext_interrupt_ff, timer0_clock_input_ff;
    logic        timer1_clock_input_ff;
    logic [3:0]  lcd_common_line_ff;
    logic [1:0]  lcd_bias_level_ff, fast_rc_freq_ff, osc_pin_used_ff;
    logic [2:0]  osc_source_ff;
    int          mismatches, compares, n;
    // Large part: output pins per select, input pins int/t0/t1, analog
    logic [23:0] oe_exp [4] = '{24'h020082, 24'h001082, 24'h001082,
                                24'h060080};
    int          in_pin [4][3] = '{'{0, 2, 6}, '{3, 2, 4}, '{0, 2, 4},
                                   '{19, 20, 6}};
    logic [23:0] an_exp [4] = '{24'h002f00, 24'h010078, 24'h010460,
                                24'h000f08};
    logic [1:0]  pins_exp [5] = '{2'h3, 2'h2, 2'h0, 2'h3, 2'h0};
    logic [31:0] small_rd, mid_rd;
    logic [23:0] small_oe, small_an, mid_oe, mid_an;
    // Small and middle parts: output pins per select
    logic [23:0] small_oe_exp [4] = '{24'h000082, 24'h000012, 24'h000180,
                                      24'h000000};
    logic [23:0] mid_oe_exp [4] = '{24'h000082, 24'h000000, 24'h000000,
                                    24'h040080};
    // ==========================================
    // Design
    pin_function_route #(.VARIANT(VAR_LARGE)) pin_function_route_i (
        .clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .pin_in(pin_in), .gpio_out(gpio_out),
        .gpio_is_input(gpio_is_input), .gpio_d_is_input(gpio_d_is_input),
        .pad_out_ff(pad_out_ff), .pad_oe_ff(pad_oe_ff),
        .pad_pull_ff(pad_pull_ff), .pad_analog_ff(pad_analog_ff),
        .pad_d_pull_ff(pad_d_pull_ff), .freq_div_in(freq_div_in),
        .pulse_width_out_0_in(pulse_width_out_0_in), .pulse_width_out_1_in(pulse_width_out_1_in),
        .ext_interrupt_ff(ext_interrupt_ff),
        .timer0_clock_input_ff(timer0_clock_input_ff),
        .timer1_clock_input_ff(timer1_clock_input_ff),
        .sleep_mode(sleep_mode), .wake_req_ff(wake_req_ff),
        .lcd_common_line_ff(lcd_common_line_ff),
        .lcd_bias_level_ff(lcd_bias_level_ff),
        .osc_source_ff(osc_source_ff), .fast_rc_freq_ff(fast_rc_freq_ff),
        .osc_pin_used_ff(osc_pin_used_ff)
    );
    // Small and middle parts share the stimulus
    pin_function_route #(.VARIANT(VAR_SMALL)) pin_function_route_small_i (
        .clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata_ff(small_rd), .pready_ff(), .pslverr_ff(),
        .pin_in(pin_in), .gpio_out(gpio_out),
        .gpio_is_input(gpio_is_input), .gpio_d_is_input(gpio_d_is_input),
        .pad_out_ff(), .pad_oe_ff(small_oe), .pad_pull_ff(),
        .pad_analog_ff(small_an), .pad_d_pull_ff(),
        .freq_div_in(freq_div_in), .pulse_width_out_0_in(pulse_width_out_0_in), .pulse_width_out_1_in(pulse_width_out_1_in),
        .ext_interrupt_ff(), .timer0_clock_input_ff(),
        .timer1_clock_input_ff(), .sleep_mode(sleep_mode),
        .wake_req_ff(), .lcd_common_line_ff(), .lcd_bias_level_ff(),
        .osc_source_ff(), .fast_rc_freq_ff(), .osc_pin_used_ff()
    );
    pin_function_route #(.VARIANT(VAR_MID)) pin_function_route_mid_i (
        .clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata_ff(mid_rd), .pready_ff(), .pslverr_ff(),
        .pin_in(pin_in), .gpio_out(gpio_out),
        .gpio_is_input(gpio_is_input), .gpio_d_is_input(gpio_d_is_input),
        .pad_out_ff(), .pad_oe_ff(mid_oe), .pad_pull_ff(),
        .pad_analog_ff(mid_an), .pad_d_pull_ff(),
        .freq_div_in(freq_div_in), .pulse_width_out_0_in(pulse_width_out_0_in), .pulse_width_out_1_in(pulse_width_out_1_in),
        .ext_interrupt_ff(), .timer0_clock_input_ff(),
        .timer1_clock_input_ff(), .sleep_mode(sleep_mode),
        .wake_req_ff(), .lcd_common_line_ff(), .lcd_bias_level_ff(),
        .osc_source_ff(), .fast_rc_freq_ff(), .osc_pin_used_ff()
    );
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ==========================================
    // Tasks
    task automatic conclude();
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask
    // Setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clock);
            if (pready_ff === 1'b1)
                break;
        end
        if (i == 20)
        begin
            check("apb_timeout", 32'h1, 32'h0);
            conclude();
        end
        else
        begin
            rd      = prdata_ff;
            err     = pslverr_ff;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Count wake pulses over a fixed window
    task automatic fall_pa0(output int pulses);
        pulses = 0;
        pin_in[0] <= 1'b1;
        tick(8);
        pin_in[0] <= 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            tick(1);
            if (wake_req_ff === 1'b1)
                pulses++;
        end
    endtask
    // ==========================================
    // Sequence
    initial
    begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; pin_in = 24'h0; gpio_out = 24'h0;
        gpio_is_input = 24'hffffff; gpio_d_is_input = 8'h00;
        freq_div_in = 1'b1; pulse_width_out_0_in = 1'b0; pulse_width_out_1_in = 1'b1;
        sleep_mode = 1'b0; mismatches = 0; compares = 0;
        tick(5);
        rst <= 1'b0;
        tick(1);
        apb(1'b0, OFS_ROUTE, 32'h0);
        check("route_reset", rd, 32'h0);
        apb(1'b0, OFS_OSC, 32'h0);
        check("osc_reset", rd, 32'h2);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped_err", {31'h0, err}, 32'h1);
        apb(1'b1, OFS_ROUTE, 32'hffffffff);
        apb(1'b0, OFS_ROUTE, 32'h0);
        check("route_bits", rd, 32'h0f);
        check("small_bits", small_rd, 32'h0d);
        check("mid_bits", mid_rd, 32'h0c);
        // Back-to-back selects; stale pins must drop out
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, OFS_ROUTE, 32'(s * 4));
            tick(3);
            check("route_oe", pad_oe_ff, oe_exp[s]);
            check("route_out", pad_out_ff & oe_exp[s],
                  oe_exp[s] & 24'hffff7f);
            check("small_oe", small_oe, small_oe_exp[s]);
            check("mid_oe", mid_oe, mid_oe_exp[s]);
            for (int f = 0; f < 3; f++)
            begin
                pin_in <= 24'h1 << in_pin[s][f];
                tick(8);
                check("route_in", {ext_interrupt_ff, timer0_clock_input_ff,
                    timer1_clock_input_ff}, 32'(3'b100 >> f));
            end
            pin_in <= 24'h0;
        end
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, OFS_ROUTE, 32'(s));
            tick(3);
            check("analog", pad_analog_ff, an_exp[s]);
            check("small_an", small_an, (s % 2) ? 32'h08 : 32'h20);
            check("mid_an", mid_an, 32'h0);
        end
        apb(1'b1, OFS_ROUTE, 32'h0);
        // Pull-high only on inputs not claimed by outputs
        apb(1'b1, OFS_PULL_A, 32'hff);
        tick(3);
        check("pull_a", pad_pull_ff[7:0], 32'h7d);
        gpio_is_input[0] <= 1'b0;
        tick(3);
        check("pull_a_out", pad_pull_ff[7:0], 32'h7c);
        apb(1'b1, OFS_PULL_D, 32'h0f);
        gpio_d_is_input <= 8'h03;
        tick(3);
        check("pull_d", pad_d_pull_ff, 32'h03);
        gpio_is_input[0] <= 1'b1;
        // Wake only in sleep and only on enabled pins
        apb(1'b1, OFS_WAKE, 32'h01);
        fall_pa0(n);
        check("wake_awake", n, 32'h0);
        sleep_mode <= 1'b1;
        fall_pa0(n);
        check("wake_sleep", n, 32'h1);
        apb(1'b1, OFS_WAKE, 32'h02);
        fall_pa0(n);
        check("wake_masked", n, 32'h0);
        sleep_mode <= 1'b0;
        apb(1'b1, OFS_LCD, 32'hff);
        apb(1'b0, OFS_LCD, 32'h0);
        check("lcd_read", rd, 32'h3f);
        tick(2);
        check("lcd_lines", {lcd_bias_level_ff, lcd_common_line_ff},
              32'h3f);
        // Oscillator sources; PA5 stays I/O except with a crystal
        gpio_is_input[5] <= 1'b0;
        gpio_out[5]      <= 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            apb(1'b1, OFS_OSC, 32'(k) | 32'h20);
            tick(3);
            check("osc_src", osc_source_ff, 32'(k));
            check("osc_rc", fast_rc_freq_ff, 32'(RC_12MHZ));
            check("osc_pins", osc_pin_used_ff, pins_exp[k]);
            check("pa5_io", pad_oe_ff[5], 32'(pins_exp[k] != 2'h3));
        end
        apb(1'b1, OFS_OSC, 32'hff);
        apb(1'b0, OFS_OSC, 32'h0);
        check("osc_bits", rd, 32'h37);
        conclude();
    end
endmodule // test_pin_function_route
`default_nettype wire
